//--- include/ssc_conv_if.sv
`timescale 1ns/1ps
interface ssc_conv_if;
    logic start;
    logic bipolar;
    logic agr_en;
    logic comp_above;
    logic small_signal;
    logic [ssc_pkg::CODE_WIDTH-1:0] dac_code;
    logic gain_boost;
    logic done;
    logic [ssc_pkg::CODE_WIDTH-1:0] code;

    modport ctrl (
        output start, bipolar, agr_en, comp_above, small_signal,
        input dac_code, gain_boost, done, code
    );
    modport conv (
        input start, bipolar, agr_en, comp_above, small_signal,
        output dac_code, gain_boost, done, code
    );
endinterface

//--- include/ssc_pkg.sv
package ssc_pkg;

    // Channel and code geometry.
    localparam int CHANNELS = 8;
    localparam int CODE_WIDTH = 20;
    localparam int RANGE_WIDTH = 4;
    localparam int LANE_WIDTH = 3;
    localparam int ADDR_WIDTH = 12;
    localparam int INDEX_WIDTH = 10;
    localparam int DATA_WIDTH = 32;
    localparam int COUNT_WIDTH = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [INDEX_WIDTH-1:0] RANGE_IDX_BASE = 10'h02a;
    localparam logic [INDEX_WIDTH-1:0] RANGE_IDX_STEP = 10'h012;
    localparam logic [INDEX_WIDTH-1:0] AGR_IDX = 10'h004;
    localparam logic [INDEX_WIDTH-1:0] LANE_IDX = 10'h005;
    localparam logic [INDEX_WIDTH-1:0] STATUS_IDX = 10'h006;

    // Status register bit positions.
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LVDS_BIT = 1;
    localparam int STATUS_OVERRUN_BIT = 2;
    localparam int STATUS_COUNT_LSB = 16;

    // Values after reset.
    localparam logic [RANGE_WIDTH-1:0] RANGE_RESET = 4'hf;
    localparam logic [CHANNELS-1:0] AGR_RESET = 8'hff;
    localparam logic [LANE_WIDTH-1:0] LANE_RESET = 3'h7;

    // Successive approximation: first trial weight and number of steps.
    localparam logic [CODE_WIDTH-1:0] SAR_FIRST_BIT = 20'h80000;
    localparam int SAR_STEPS = 20;

    typedef logic [CODE_WIDTH-1:0] ssc_code_type;
    typedef logic [RANGE_WIDTH-1:0] ssc_range_type;

    typedef enum logic [1:0] {
        SSC_CTRL_IDLE = 2'b00,
        SSC_CTRL_CONVERT = 2'b01
    } ssc_ctrl_state_type;

    typedef enum logic [1:0] {
        SSC_CONV_IDLE = 2'b00,
        SSC_CONV_GAIN = 2'b01,
        SSC_CONV_SAR = 2'b10,
        SSC_CONV_DONE = 2'b11
    } ssc_conv_state_type;

    // Odd range codes are bipolar, even ones unipolar.
    function automatic logic ssc_is_bipolar(input ssc_range_type range);
        return range[0];
    endfunction

    // Raw SAR result is offset binary over the span actually used. A boosted
    // sample spans a quarter of the range, so it is shifted back into range scale.
    function automatic ssc_code_type ssc_format(input ssc_code_type raw, input logic bipolar,
                                                input logic boost);
        ssc_code_type twos;
        twos = {~raw[CODE_WIDTH-1], raw[CODE_WIDTH-2:0]};
        if (bipolar && boost) begin
            return {{2{twos[CODE_WIDTH-1]}}, twos[CODE_WIDTH-1:2]};
        end else if (bipolar) begin
            return twos;
        end else if (boost) begin
            return {2'b00, raw[CODE_WIDTH-1:2]};
        end else begin
            return raw;
        end
    endfunction

    // Register index of a channel's range register.
    function automatic logic [INDEX_WIDTH-1:0] ssc_range_index(input int ch);
        return RANGE_IDX_BASE + INDEX_WIDTH'(ch) * RANGE_IDX_STEP;
    endfunction

    // Lane count is stored minus one; lanes 0..count are active.
    function automatic logic [CHANNELS-1:0] ssc_lane_mask(input logic [LANE_WIDTH-1:0] count);
        logic [CHANNELS-1:0] mask;
        mask = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            mask[i] = (LANE_WIDTH'(i) <= count);
        end
        return mask;
    endfunction

endpackage

//--- logic/ssc_channel_conv.sv
`timescale 1ns/1ps
module ssc_channel_conv (
    input wire logic clk,
    input wire logic srst,
    ssc_conv_if.conv bus
);
    import ssc_pkg::*;

    ssc_conv_state_type state, next_state;
    ssc_code_type trial, next_trial;
    ssc_code_type mask, next_mask;
    ssc_code_type code, next_code;
    logic boost, next_boost;
    logic bipolar, next_bipolar;
    ssc_code_type kept;

    // One gain decision cycle, then one comparator decision per code bit.
    always_comb begin
        next_state = state;
        next_trial = trial;
        next_mask = mask;
        next_code = code;
        next_boost = boost;
        next_bipolar = bipolar;
        kept = bus.comp_above ? trial : (trial & ~mask);
        case (state)
            SSC_CONV_IDLE: begin
                if (bus.start) begin
                    next_state = SSC_CONV_GAIN;
                    next_bipolar = bus.bipolar;
                    next_boost = 1'b0;
                end
            end
            SSC_CONV_GAIN: begin
                // Gain is picked anew for each sample.
                next_boost = bus.agr_en & bus.small_signal;
                next_trial = SAR_FIRST_BIT;
                next_mask = SAR_FIRST_BIT;
                next_state = SSC_CONV_SAR;
            end
            SSC_CONV_SAR: begin
                if (mask[0]) begin
                    next_trial = kept;
                    next_code = ssc_format(kept, bipolar, boost);
                    next_state = SSC_CONV_DONE;
                end else begin
                    next_mask = mask >> 1;
                    next_trial = kept | (mask >> 1);
                end
            end
            SSC_CONV_DONE: begin
                next_state = SSC_CONV_IDLE;
            end
            default: begin
                next_state = SSC_CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= SSC_CONV_IDLE;
            trial <= '0;
            mask <= '0;
            code <= '0;
            boost <= 1'b0;
            bipolar <= 1'b1;
        end else begin
            state <= next_state;
            trial <= next_trial;
            mask <= next_mask;
            code <= next_code;
            boost <= next_boost;
            bipolar <= next_bipolar;
        end
    end

    // All outputs come from the registers above.
    assign bus.dac_code = trial;
    assign bus.gain_boost = boost;
    assign bus.done = (state == SSC_CONV_DONE);
    assign bus.code = code;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence conv_begin;
        bus.start && state == SSC_CONV_IDLE;
    endsequence

    sar_length_a: assert property (conv_begin |-> ##22 bus.done)
        else $error("Channel conversion did not finish 22 cycles after start.");
    gain_pick_a: assert property (
        state == SSC_CONV_GAIN |=> boost == $past(bus.agr_en && bus.small_signal))
        else $error("Gain boost does not follow enable and signal size.");
    bipolar_format_a: assert property (
        bus.done && bipolar && !boost |-> code == {~trial[19], trial[18:0]})
        else $error("Bipolar code is not twos complement.");
    unipolar_format_a: assert property (bus.done && !bipolar && !boost |-> code == trial)
        else $error("Unipolar code is not straight binary.");
    boost_scale_a: assert property (
        bus.done && boost |->
            (bipolar ? (code[19] == code[17] && code[18] == code[17]) : code[19:18] == 2'b00))
        else $error("Boosted sample is not in the range scale.");

endmodule // ssc_channel_conv

//--- logic/ssc_top.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ssc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic conversion_start_pin,
    input wire logic lvds_select,
    input wire logic [ssc_pkg::CHANNELS-1:0] comp_above,
    input wire logic [ssc_pkg::CHANNELS-1:0] small_signal,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssc_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [ssc_pkg::DATA_WIDTH-1:0] pwdata,
    output logic pready,
    output logic [ssc_pkg::DATA_WIDTH-1:0] prdata,
    output logic pslverr,
    output logic sample_hold,
    output logic result_valid,
    output logic [ssc_pkg::CHANNELS-1:0][ssc_pkg::CODE_WIDTH-1:0] result_code,
    output logic [ssc_pkg::CHANNELS-1:0][ssc_pkg::CODE_WIDTH-1:0] sar_dac_code,
    output logic [ssc_pkg::CHANNELS-1:0] gain_boost,
    output logic [ssc_pkg::CHANNELS-1:0] cmos_lane_enable
);
    import ssc_pkg::*;

    ssc_conv_if conv_bus [CHANNELS] ();

    // Conversion control state.
    ssc_ctrl_state_type state, next_state;
    logic start_prev, next_start_prev;
    logic next_sample_hold;
    logic chan_start, next_chan_start;
    logic [CHANNELS-1:0] conv_bipolar, next_conv_bipolar;
    logic [CHANNELS-1:0] conv_agr, next_conv_agr;
    logic next_result_valid;
    logic [CHANNELS-1:0][CODE_WIDTH-1:0] next_result_code;
    logic [COUNT_WIDTH-1:0] conv_count, next_conv_count;
    logic overrun, next_overrun;

    // Register file state.
    logic [CHANNELS-1:0][RANGE_WIDTH-1:0] range_code, next_range_code;
    logic [CHANNELS-1:0] agr_enable, next_agr_enable;
    logic [LANE_WIDTH-1:0] lane_count, next_lane_count;
    logic [CHANNELS-1:0] next_cmos_lane_enable;
    logic next_pready;
    logic [DATA_WIDTH-1:0] next_prdata;
    logic next_pslverr;

    // Decode and gathered channel results.
    logic start_rise;
    logic [CHANNELS-1:0] done_vec;
    logic [CHANNELS-1:0][CODE_WIDTH-1:0] code_vec;
    logic [INDEX_WIDTH-1:0] index;
    logic range_hit;
    logic [LANE_WIDTH-1:0] range_ch;
    logic known;
    logic setup;
    logic write_now;
    logic [DATA_WIDTH-1:0] read_word;

    // One converter per channel, all started by the same pulse.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            ssc_channel_conv u_conv (
                .clk(clk),
                .srst(srst),
                .bus(conv_bus[g].conv)
            );
            assign conv_bus[g].start = chan_start;
            assign conv_bus[g].bipolar = conv_bipolar[g];
            assign conv_bus[g].agr_en = conv_agr[g];
            assign conv_bus[g].comp_above = comp_above[g];
            assign conv_bus[g].small_signal = small_signal[g];
            assign done_vec[g] = conv_bus[g].done;
            assign code_vec[g] = conv_bus[g].code;
            assign sar_dac_code[g] = conv_bus[g].dac_code;
            assign gain_boost[g] = conv_bus[g].gain_boost;
        end
    endgenerate

    assign start_rise = conversion_start_pin & ~start_prev;
    assign setup = psel & ~penable;
    assign write_now = psel & penable & pready & pwrite & ~pslverr;

    // Conversion sequencing. Ranges are frozen at the start edge so a write
    // during a conversion cannot change the format of the sample in flight.
    always_comb begin
        next_state = state;
        next_start_prev = conversion_start_pin;
        next_sample_hold = sample_hold;
        next_chan_start = 1'b0;
        next_conv_bipolar = conv_bipolar;
        next_conv_agr = conv_agr;
        next_result_valid = 1'b0;
        next_result_code = result_code;
        next_conv_count = conv_count;
        next_overrun = overrun;
        // Software clears the overrun flag by writing one to it.
        if (write_now && index == STATUS_IDX && pwdata[STATUS_OVERRUN_BIT]) begin
            next_overrun = 1'b0;
        end
        case (state)
            SSC_CTRL_IDLE: begin
                if (start_rise) begin
                    next_state = SSC_CTRL_CONVERT;
                    next_sample_hold = 1'b1;
                    next_chan_start = 1'b1;
                    next_conv_agr = agr_enable;
                    for (int i = 0; i < CHANNELS; i++) begin
                        next_conv_bipolar[i] = ssc_is_bipolar(range_code[i]);
                    end
                end
            end
            SSC_CTRL_CONVERT: begin
                // A start edge while converting is dropped; the set wins a clear.
                if (start_rise) begin
                    next_overrun = 1'b1;
                end
                if (&done_vec) begin
                    next_result_code = code_vec;
                    next_result_valid = 1'b1;
                    next_sample_hold = 1'b0;
                    next_conv_count = conv_count + 1'b1;
                    next_state = SSC_CTRL_IDLE;
                end
            end
            default: begin
                next_state = SSC_CTRL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= SSC_CTRL_IDLE;
            start_prev <= 1'b0;
            sample_hold <= 1'b0;
            chan_start <= 1'b0;
            conv_bipolar <= '0;
            conv_agr <= '0;
            result_valid <= 1'b0;
            result_code <= '0;
            conv_count <= '0;
            overrun <= 1'b0;
        end else begin
            state <= next_state;
            start_prev <= next_start_prev;
            sample_hold <= next_sample_hold;
            chan_start <= next_chan_start;
            conv_bipolar <= next_conv_bipolar;
            conv_agr <= next_conv_agr;
            result_valid <= next_result_valid;
            result_code <= next_result_code;
            conv_count <= next_conv_count;
            overrun <= next_overrun;
        end
    end

    // Address decode; only aligned addresses of known registers are mapped.
    always_comb begin
        index = paddr[ADDR_WIDTH-1:2];
        range_hit = 1'b0;
        range_ch = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (index == ssc_range_index(i)) begin
                range_hit = 1'b1;
                range_ch = LANE_WIDTH'(i);
            end
        end
        known = (paddr[1:0] == 2'b00) &&
                (range_hit || index == AGR_IDX || index == LANE_IDX || index == STATUS_IDX);
        read_word = '0;
        if (range_hit) begin
            read_word[RANGE_WIDTH-1:0] = range_code[range_ch];
        end else if (index == AGR_IDX) begin
            read_word[CHANNELS-1:0] = agr_enable;
        end else if (index == LANE_IDX) begin
            read_word[LANE_WIDTH-1:0] = lane_count;
        end else if (index == STATUS_IDX) begin
            read_word[STATUS_BUSY_BIT] = sample_hold;
            read_word[STATUS_LVDS_BIT] = lvds_select;
            read_word[STATUS_OVERRUN_BIT] = overrun;
            read_word[STATUS_COUNT_LSB +: COUNT_WIDTH] = conv_count;
        end
    end

    // APB slave with zero wait states: the answer is prepared in the setup
    // cycle, so pready, prdata and pslverr all come from flops.
    always_comb begin
        next_pready = setup;
        next_pslverr = setup & ~known;
        next_prdata = (setup && !pwrite && known) ? read_word : '0;
        next_range_code = range_code;
        next_agr_enable = agr_enable;
        next_lane_count = lane_count;
        if (write_now && range_hit) begin
            next_range_code[range_ch] = pwdata[RANGE_WIDTH-1:0];
        end
        if (write_now && index == AGR_IDX) begin
            next_agr_enable = pwdata[CHANNELS-1:0];
        end
        if (write_now && index == LANE_IDX) begin
            next_lane_count = pwdata[LANE_WIDTH-1:0];
        end
        // LVDS mode leaves every CMOS lane idle.
        next_cmos_lane_enable = lvds_select ? '0 : ssc_lane_mask(lane_count);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            range_code <= {CHANNELS{RANGE_RESET}};
            agr_enable <= AGR_RESET;
            lane_count <= LANE_RESET;
            cmos_lane_enable <= '0;
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            range_code <= next_range_code;
            agr_enable <= next_agr_enable;
            lane_count <= next_lane_count;
            cmos_lane_enable <= next_cmos_lane_enable;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence accepted_start;
        start_rise && state == SSC_CTRL_IDLE;
    endsequence

    sequence range_write;
        write_now && range_hit;
    endsequence

    hold_start_a: assert property (accepted_start |=> sample_hold && chan_start)
        else $error("Start edge did not hold and start all channels.");
    conv_latency_a: assert property (accepted_start |-> ##24 result_valid)
        else $error("Results not ready 24 cycles after start.");
    hold_through_a: assert property (accepted_start |=> sample_hold [*8])
        else $error("Hold dropped early during a conversion.");
    result_update_a: assert property ($changed(result_code) |-> result_valid)
        else $error("Result codes changed outside conversion end.");
    polarity_pick_a: assert property (
        accepted_start |=> conv_bipolar[0] == $past(range_code[0][0]) &&
                           conv_bipolar[7] == $past(range_code[7][0]))
        else $error("Polarity does not follow range code parity.");
    range_reset_a: assert property ($fell(srst) |-> range_code == {CHANNELS{RANGE_RESET}})
        else $error("Range codes not 15 after reset.");
    range_write_a: assert property (
        range_write |=> range_code[$past(range_ch)] == $past(pwdata[3:0]))
        else $error("Range write did not reach its channel.");
    // The enables still hold their reset value at the first edge after release.
    lane_mask_a: assert property (
        !$past(srst) && !$past(lvds_select) |->
            cmos_lane_enable == ssc_lane_mask($past(lane_count)))
        else $error("CMOS lane enables do not match lane count.");
    lvds_idle_a: assert property ($past(lvds_select) |-> cmos_lane_enable == '0)
        else $error("CMOS lanes active in LVDS mode.");

endmodule // ssc_top

//--- tb/ssc_afe_model.sv
`timescale 1ns/1ps
// Behavioural analog front end: a held sample per channel, a comparator and a size detector.
module ssc_afe_model (
    input wire logic [ssc_pkg::CHANNELS-1:0][ssc_pkg::CODE_WIDTH-1:0] sample,
    input wire logic [ssc_pkg::CHANNELS-1:0] bipolar,
    input wire logic [ssc_pkg::CHANNELS-1:0][ssc_pkg::CODE_WIDTH-1:0] sar_dac_code,
    input wire logic [ssc_pkg::CHANNELS-1:0] gain_boost,
    output logic [ssc_pkg::CHANNELS-1:0] comp_above,
    output logic [ssc_pkg::CHANNELS-1:0] small_signal
);
    import ssc_pkg::*;

    // Raised gain stretches the sample four times about zero, so a boosted compare only
    // makes sense for small samples; a large one would wrap, as it would saturate in silicon.
    // Signed literals keep the size test signed; unsigned ones would miss every sample.
    always_comb begin
        int d;
        int eff;
        d = 0;
        eff = 0;
        for (int c = 0; c < CHANNELS; c++) begin
            d = int'(sample[c]) - 32'sh80000;
            small_signal[c] = bipolar[c] ? (d > -32'sh20000 && d < 32'sh20000)
                                         : (sample[c] < 20'h40000);
            if (gain_boost[c]) begin
                eff = bipolar[c] ? 32'sh80000 + 4 * d : 4 * int'(sample[c]);
            end else begin
                eff = int'(sample[c]);
            end
            comp_above[c] = (CODE_WIDTH'(eff) >= sar_dac_code[c]);
        end
    end
endmodule // ssc_afe_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    import ssc_pkg::*;
    localparam logic [11:0] A_AGR = 12'h010;
    localparam logic [11:0] A_LANE = 12'h014;
    localparam logic [11:0] A_STAT = 12'h018;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic conversion_start_pin = 1'b0;
    logic lvds_select = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_WIDTH-1:0] paddr = '0;
    logic [DATA_WIDTH-1:0] pwdata = '0;
    logic pready, pslverr, sample_hold, result_valid, err;
    logic [DATA_WIDTH-1:0] prdata, rd;
    logic [CHANNELS-1:0][CODE_WIDTH-1:0] result_code, sar_dac_code, prev_code;
    logic [CHANNELS-1:0][CODE_WIDTH-1:0] sample = {20'hc8000, 20'h3abcd, 20'h90000, 20'h12345,
        20'hfffff, 20'h7fff0, 20'h80010, 20'h00001};
    logic [CHANNELS-1:0] comp_above, small_signal, gain_boost, cmos_lane_enable;
    logic [CHANNELS-1:0] bipolar = 8'hff;
    logic [CHANNELS-1:0] agr = 8'hff;
    int n_fail = 0;
    int tests_run = 0;

    ssc_top i_dut (.clk(clk), .srst(srst), .conversion_start_pin(conversion_start_pin),
        .lvds_select(lvds_select), .comp_above(comp_above), .small_signal(small_signal),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_hold(sample_hold),
        .result_valid(result_valid), .result_code(result_code), .sar_dac_code(sar_dac_code),
        .gain_boost(gain_boost), .cmos_lane_enable(cmos_lane_enable));

    ssc_afe_model i_afe (.sample(sample), .bipolar(bipolar), .sar_dac_code(sar_dac_code),
        .gain_boost(gain_boost), .comp_above(comp_above), .small_signal(small_signal));

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] range_addr(input int ch);
        return 12'(4 * (int'(RANGE_IDX_BASE) + ch * int'(RANGE_IDX_STEP)));
    endfunction

    // One conversion; a glitch run drops and re-raises the start pin while busy.
    task automatic convert(input bit glitch);
        int n;
        @(posedge clk);
        conversion_start_pin <= 1'b1;
        for (n = 1; n <= 24; n++) begin
            @(posedge clk);
            if (glitch && n == 5) conversion_start_pin <= 1'b0;
            if (glitch && n == 7) conversion_start_pin <= 1'b1;
            #1;
            check("sample_hold", 32'(sample_hold), 32'(n < 24));
            check("result_valid", 32'(result_valid), 32'(n == 24));
            if (n == 3) check("first trial", 32'(sar_dac_code[0]), 32'(SAR_FIRST_BIT));
            if (n == 5) check("gain_boost", 32'(gain_boost), 32'(agr & small_signal));
            if (n == 12) begin
                for (int c = 0; c < CHANNELS; c++) begin
                    check("held code", 32'(result_code[c]), 32'(prev_code[c]));
                end
            end
        end
        // Bipolar codes are the offset-binary sample with the top bit flipped.
        for (int c = 0; c < CHANNELS; c++) begin
            prev_code[c] = bipolar[c] ? sample[c] ^ 20'h80000 : sample[c];
            check("result_code", 32'(result_code[c]), 32'(prev_code[c]));
        end
        @(posedge clk);
        conversion_start_pin <= 1'b0;
        @(posedge clk);
    endtask

    // Main sequence.
    initial begin
        prev_code = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check("lanes after reset", 32'(cmos_lane_enable), 32'hff);
        for (int ch = 0; ch < CHANNELS; ch++) begin
            apb(1'b0, range_addr(ch), 32'h0, rd, err);
            check("range reset", rd, 32'hf);
            check("range reset err", 32'(err), 32'h0);
        end
        apb(1'b0, A_AGR, 32'h0, rd, err);
        check("agr reset", rd, 32'hff);
        apb(1'b0, 12'h0fc, 32'h0, rd, err);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        // Pass 0 sets the odd codes, pass 1 the even ones, a different code on every channel.
        for (int p = 0; p < 2; p++) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                apb(1'b1, range_addr(ch), 32'(2 * ch + 1 - p), rd, err);
                bipolar[ch] = (p == 0);
            end
            for (int ch = 0; ch < CHANNELS; ch++) begin
                apb(1'b0, range_addr(ch), 32'h0, rd, err);
                check("range readback", rd, 32'(2 * ch + 1 - p));
            end
            agr = p ? 8'hf0 : 8'h0f;
            apb(1'b1, A_AGR, 32'(agr), rd, err);
            convert(1'b0);
        end
        convert(1'b1);
        apb(1'b0, A_STAT, 32'h0, rd, err);
        check("status overrun", rd, 32'h00030004);
        apb(1'b1, A_STAT, 32'h4, rd, err);
        apb(1'b0, A_STAT, 32'h0, rd, err);
        check("status cleared", rd, 32'h00030000);
        apb(1'b1, A_LANE, 32'h2, rd, err);
        repeat (2) @(posedge clk);
        #1;
        check("three lanes", 32'(cmos_lane_enable), 32'h07);
        @(posedge clk);
        lvds_select <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("lvds lanes off", 32'(cmos_lane_enable), 32'h00);
        apb(1'b0, A_STAT, 32'h0, rd, err);
        check("status lvds", rd, 32'h00030002);
        report_and_stop;
    end

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end
endmodule // tb
